/* File: common/mfh_pkg.sv */
// Package for the micro finish, halt and refresh sequencing control.
// Assumes a single 200 MHz clock; all timing counts derive from it.
package mfh_pkg;

    // ********************
    // Timing constants.
    // ********************
    localparam int CLK_MHZ            = 200;     // Clock rate in MHz.
    localparam int PULSE_CYCLES       = 2;       // Console pulse length.
    localparam int REFRESH_TIMER_US   = 62;      // Refresh timer in us.
    localparam int DEMAND_REFRESH_MS  = 62;      // Demand period in ms.
    // Refresh timer in clock cycles, an exact product so nothing is rounded.
    localparam int REFRESH_TIMER_CYC  = REFRESH_TIMER_US * CLK_MHZ;
    // Demand refresh period in clock cycles.
    localparam int DEMAND_REFRESH_CYC = DEMAND_REFRESH_MS * 1000 * CLK_MHZ;
    localparam int SEQ_ENABLES        = 4;       // Sequence enable count.
    localparam int PARITY_MODULES     = 4;       // Memory module count.

    // ********************
    // Interrupt status bit positions.
    // ********************
    localparam int IRQ_HALTED  = 0;              // Processor halted.
    localparam int IRQ_REFRESH = 1;              // Refresh granted.
    localparam int IRQ_BADPAR  = 2;              // Bad parity forced.
    localparam int IRQ_BITS    = 3;              // Status width.

    // ********************
    // Register indices on the plain register port.
    // ********************
    localparam logic [3:0] REG_STATUS  = 4'h0;   // Sticky events.
    localparam logic [3:0] REG_MASK    = 4'h1;   // Interrupt mask.
    localparam logic [3:0] REG_CONTROL = 4'h2;   // Step mode control.
    localparam logic [3:0] REG_STATE   = 4'h3;   // Live state view.
    localparam int CTRL_STEP = 0;                // Step mode bit.

    // ********************
    // Carriers.
    // ********************
    // Halt sources gathered from the decoder, tape and fetch logic.
    typedef struct packed {
        logic halt_micro;        // Halt micro decoded.
        logic fetch_parity_err;  // Parity error on micro fetch.
        logic tape_parity_err;   // Cassette parity error.
        logic stop_at_gap;       // Stop at gap micro.
        logic stop_unequal;      // Stop on unequal micro.
    } mfh_halt_src_t;

    // Bounds check inputs from the address path.
    typedef struct packed {
        logic       out_of_bounds;   // Address outside bounds.
        logic       at_upper_limit;  // Address at upper limit.
        logic [1:0] limit_module;    // Module chosen at the limit.
        logic [3:0] module_oob;      // Module lies out of bounds.
        logic       key_in_bounds;   // Key byte address in bounds.
    } mfh_bounds_t;

    // Forced parity terms toward S-memory.
    typedef struct packed {
        logic       force_parity_bad;            // Force a parity error.
        logic [2:0] force_parity_good_limit;     // Good parity at limit.
        logic [3:0] force_parity_good_module_n;  // Good parity per module.
    } mfh_parity_t;

endpackage : mfh_pkg

/* File: rtl/mfh_ctl.sv */
// Micro finish, halt, run state and S-memory refresh sequencing control.
// Assumes console buttons are already debounced and synchronous to clk_in.

// What this block does
// - Finish only with a sequence enable asserted.
// - Registered finish fed to console flops.
// - Advance micro address unless refresh granted.
// - Halt button gives two-cycle pulse, sets pending.
// - Pending halt stops run at finish.
// - Listed halt sources reset the run flop, the gap and unequal stops only in tape run mode.
// - Halted state shown whenever run cleared.
// - Load timing pulse only while halted.
// - Defer refresh on sink, jump, halt pending.
// - Grant refresh only without console clear.
// - Reset refresh control on timer expiry.
// - General clear from console or power-up.
// - Force bad parity when out of bounds.
// - Force good parity at limit for modules 0 to 2.
// - Force good parity for out-of-bounds modules while the key byte address is in bounds.
// - Demand refresh set every 62 ms.
// - Suppress general clear during granted refresh.
module mfh_ctl #(
    parameter int REFRESH_TIMER = mfh_pkg::REFRESH_TIMER_CYC,
    parameter int DEMAND_PERIOD = mfh_pkg::DEMAND_REFRESH_CYC
) (
    // Clock and reset.
    input  wire logic                        clk_in,
    input  wire logic                        reset_in,
    // Micro decoder.
    input  wire logic [mfh_pkg::SEQ_ENABLES-1:0] sequence_enable_n_in,
    input  wire logic                        micro_timing_in,
    input  wire logic                        micro_sink_in,
    input  wire logic                        jump_pending_in,
    input  wire mfh_pkg::mfh_halt_src_t      halt_src_in,
    input  wire logic                        tape_run_mode_in,
    // Console pushbuttons.
    input  wire logic                        halt_button_in,
    input  wire logic                        load_button_in,
    input  wire logic                        clear_button_in,
    input  wire logic                        start_button_in,
    input  wire logic                        power_up_clear_in,
    // S-memory.
    input  wire logic                        refresh_request_in,
    input  wire mfh_pkg::mfh_bounds_t        bounds_in,
    // Register port.
    input  wire logic [3:0]                  reg_addr_in,
    input  wire logic [31:0]                 reg_wdata_in,
    input  wire logic                        reg_write_in,
    input  wire logic                        reg_read_in,
    output logic [31:0]                      reg_rdata_out,
    // Sequencing outputs.
    output logic                             micro_done_out,
    output logic                             micro_done_console_out,
    output logic                             done_advance_ok_out,
    output logic [15:0]                      micro_address_out,
    output logic                             halt_pending_out,
    output logic                             run_flop_out,
    output logic                             halted_state_out,
    output logic                             console_load_timing_out,
    output logic                             refresh_granted_flop_out,
    output logic                             demand_refresh_flop_out,
    output logic                             general_clear_out,
    output mfh_pkg::mfh_parity_t             parity_out,
    output logic                             irq_out
);
    import mfh_pkg::*;

    // ********************
    // State and combinational terms.
    // ********************
    logic        done_r;          // Registered finish term.
    logic        done_con_r;      // Finish copy for console flops.
    logic        adv_r;           // Advance permit registered.
    logic [15:0] mar_r;           // Micro address register.
    logic        pend_r;          // Halt pending flop.
    logic        run_r;           // Run flop.
    logic        halted_r;        // Halt state copy.
    logic [1:0]  halt_cnt_r;      // Halt pulse counter.
    logic        halt_btn_d_r;    // Halt button delayed.
    logic        halt_pulse;      // Two-cycle halt pulse.
    logic [1:0]  load_cnt_r;      // Load pulse counter.
    logic        load_btn_d_r;    // Load button delayed.
    logic        load_r;          // Load timing output flop.
    logic        grf_r;           // Granted refresh flop.
    logic        ctl_r;           // Refresh control flop.
    logic        drf_r;           // Demand refresh flop.
    logic [31:0] rtmr_r;          // Refresh timer.
    logic [31:0] dtmr_r;          // Demand refresh timer.
    logic        gclr_r;          // General clear output flop.
    logic        gclr;            // General clear term.
    mfh_parity_t par_r;           // Forced parity flops.
    logic        step_r;          // Step mode control bit.
    logic [IRQ_BITS-1:0] stat_r;  // Sticky status.
    logic [IRQ_BITS-1:0] mask_r;  // Interrupt mask.
    logic [IRQ_BITS-1:0] ev;      // Event strobes.
    logic        irq_r;           // Interrupt output flop.
    logic [31:0] rdata_r;         // Read data flop.
    logic        done_nxt;        // Finish term this cycle.
    logic        permit;          // Refresh hold permit.
    logic        grant_nxt;       // Refresh grant this cycle.
    logic        halt_any;        // Any halt condition.
    logic        rst;             // Combined clear.

    // Finish requires any sequence enable with micro timing.
    assign done_nxt  = (|sequence_enable_n_in) & micro_timing_in;
    // Refresh permitted unless sink, jump or halt pending.
    assign permit    = ~(micro_sink_in | jump_pending_in | pend_r);
    // Grant only while no console clear is pressed.
    assign grant_nxt = ctl_r & ~grf_r & ~clear_button_in
                       & (permit | done_nxt);
    // Clear from console or power-up, blocked by granted refresh.
    assign gclr = (clear_button_in | power_up_clear_in) & ~grf_r;
    assign rst  = reset_in | gclr;
    assign halt_pulse = (halt_cnt_r != 2'h0);
    // Halt sources reset the run flop; stop at gap and stop unequal only in tape run mode.
    assign halt_any = halt_pulse | halt_src_in.halt_micro
                    | halt_src_in.fetch_parity_err
                    | halt_src_in.tape_parity_err
                    | ((halt_src_in.stop_at_gap | halt_src_in.stop_unequal)
                       & tape_run_mode_in)
                    | (step_r & done_nxt)
                    | (pend_r & done_nxt);

    // ********************
    // Finish and micro address.
    // ********************
    // Finish is registered and advances the address unless refresh.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            done_r     <= 1'b0;
            done_con_r <= 1'b0;
            adv_r      <= 1'b0;
            mar_r      <= 16'h0000;
        end else begin
            done_r     <= done_nxt;
            done_con_r <= done_nxt;
            adv_r      <= done_nxt & ~grant_nxt;
            if (done_nxt && !grant_nxt) begin
                mar_r <= mar_r + 16'h0001;
            end
        end
    end

    // ********************
    // Halt request and run state.
    // ********************
    // Halt button edge yields a two-cycle pulse and sets pending.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            halt_cnt_r   <= 2'h0;
            halt_btn_d_r <= 1'b0;
            pend_r       <= 1'b0;
        end else begin
            halt_btn_d_r <= halt_button_in;
            if (halt_button_in && !halt_btn_d_r) begin
                halt_cnt_r <= 2'(PULSE_CYCLES);
            end else if (halt_pulse) begin
                halt_cnt_r <= halt_cnt_r - 2'h1;
            end
            if (halt_pulse) begin
                pend_r <= 1'b1;
            end else if (!run_r) begin
                pend_r <= 1'b0;              // Halt reached.
            end
        end
    end

    // Run flop sets on start and resets on any halt condition.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            run_r    <= 1'b0;
            halted_r <= 1'b1;
        end else begin
            if (halt_any) begin
                run_r    <= 1'b0;
                halted_r <= 1'b1;
            end else if (start_button_in) begin
                run_r    <= 1'b1;
                halted_r <= 1'b0;
            end
        end
    end

    // Load timing pulse of two cycles only while halted.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            load_cnt_r   <= 2'h0;
            load_btn_d_r <= 1'b0;
            load_r       <= 1'b0;
        end else begin
            load_btn_d_r <= load_button_in;
            if (load_button_in && !load_btn_d_r && halted_r) begin
                load_cnt_r <= 2'(PULSE_CYCLES - 1);
            end else if (load_cnt_r != 2'h0) begin
                load_cnt_r <= load_cnt_r - 2'h1;
            end
            load_r <= halted_r & ((load_cnt_r != 2'h0)
                     | (load_button_in & ~load_btn_d_r));
        end
    end

    // ********************
    // Refresh arbitration.
    // ********************
    // Control flop arms on demand; timer expiry without grant resets it.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            ctl_r  <= 1'b0;
            grf_r  <= 1'b0;
            rtmr_r <= 32'h0000_0000;
        end else begin
            grf_r <= grant_nxt;
            if (drf_r || refresh_request_in) begin
                ctl_r  <= 1'b1;
                rtmr_r <= 32'(REFRESH_TIMER);
            end else if (ctl_r) begin
                if (rtmr_r != 32'h0000_0000) begin
                    rtmr_r <= rtmr_r - 32'h0000_0001;
                end else if (!grf_r) begin
                    ctl_r <= 1'b0;
                end
                if (grant_nxt) begin
                    ctl_r <= 1'b0;           // Served.
                end
            end
        end
    end

    // Demand refresh flop sets once per demand period.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            drf_r  <= 1'b0;
            dtmr_r <= 32'h0000_0000;
        end else begin
            if (dtmr_r >= 32'(DEMAND_PERIOD - 1)) begin
                dtmr_r <= 32'h0000_0000;
                drf_r  <= 1'b1;
            end else begin
                dtmr_r <= dtmr_r + 32'h0000_0001;
                drf_r  <= 1'b0;
            end
        end
    end

    // ********************
    // Clear and forced parity.
    // ********************
    // General clear is registered; its flop clears on reset_in alone.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            gclr_r <= 1'b0;
        end else begin
            gclr_r <= gclr;
        end
    end

    // Forced parity terms from the bounds check.
    always_ff @(posedge clk_in) begin
        if (rst) begin
            par_r <= '0;
        end else begin
            par_r.force_parity_bad <= bounds_in.out_of_bounds;
            for (int i = 0; i < 3; i++) begin
                par_r.force_parity_good_limit[i] <=
                    bounds_in.at_upper_limit & ~bounds_in.out_of_bounds
                    & (bounds_in.limit_module == 2'(i));
            end
            par_r.force_parity_good_module_n <= bounds_in.module_oob
                & {PARITY_MODULES{bounds_in.key_in_bounds}};
        end
    end

    // ********************
    // Interrupts and register port.
    // ********************
    assign ev[IRQ_HALTED]  = halt_any & run_r;
    assign ev[IRQ_REFRESH] = grant_nxt;
    assign ev[IRQ_BADPAR]  = bounds_in.out_of_bounds;

    // Sticky status: write one clears, a new event wins over the clear.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            stat_r <= '0;
            mask_r <= '0;
            step_r <= 1'b0;
            irq_r  <= 1'b0;
        end else begin
            if (reg_write_in && reg_addr_in == REG_STATUS) begin
                stat_r <= (stat_r & ~reg_wdata_in[IRQ_BITS-1:0]) | ev;
            end else begin
                stat_r <= stat_r | ev;
            end
            if (reg_write_in && reg_addr_in == REG_MASK) begin
                mask_r <= reg_wdata_in[IRQ_BITS-1:0];
            end
            if (reg_write_in && reg_addr_in == REG_CONTROL) begin
                step_r <= reg_wdata_in[CTRL_STEP];
            end
            irq_r <= |(stat_r & mask_r);
        end
    end

    // Read data stands the cycle after the read strobe only.
    always_ff @(posedge clk_in) begin
        if (reset_in || !reg_read_in) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            unique case (reg_addr_in)
                REG_STATUS:  rdata_r <= 32'(stat_r);
                REG_MASK:    rdata_r <= 32'(mask_r);
                REG_CONTROL: rdata_r <= 32'(step_r);
                REG_STATE:   rdata_r <= {11'h000, grf_r, drf_r, pend_r,
                                         halted_r, run_r, mar_r};
                default:     rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // Outputs straight from flops.
    assign reg_rdata_out            = rdata_r;
    assign micro_done_out           = done_r;
    assign micro_done_console_out   = done_con_r;
    assign done_advance_ok_out      = adv_r;
    assign micro_address_out        = mar_r;
    assign halt_pending_out         = pend_r;
    assign run_flop_out             = run_r;
    assign halted_state_out         = halted_r;
    assign console_load_timing_out  = load_r;
    assign refresh_granted_flop_out = grf_r;
    assign demand_refresh_flop_out  = drf_r;
    assign general_clear_out        = gclr_r;
    assign parity_out               = par_r;
    assign irq_out                  = irq_r;

endmodule // mfh_ctl

/* File: tb/mfh_ctl_monitor.sv */
// Checker for the sequencing control, watching top-level ports only.
// Assumes one clk_in domain and the synchronous reset_in.
module mfh_ctl_monitor (
    input wire logic                              clk_in,
    input wire logic                              reset_in,
    input wire logic [mfh_pkg::SEQ_ENABLES-1:0]   sequence_enable_n_in,
    input wire logic                              micro_timing_in,
    input wire mfh_pkg::mfh_halt_src_t            halt_src_in,
    input wire logic                              halt_button_in,
    input wire logic                              clear_button_in,
    input wire logic                              power_up_clear_in,
    input wire mfh_pkg::mfh_bounds_t              bounds_in,
    input wire logic                              micro_done_out,
    input wire logic [15:0]                       micro_address_out,
    input wire logic                              halt_pending_out,
    input wire logic                              run_flop_out,
    input wire logic                              halted_state_out,
    input wire logic                              console_load_timing_out,
    input wire logic                              refresh_granted_flop_out,
    input wire logic                              general_clear_out,
    input wire mfh_pkg::mfh_parity_t              parity_out
);
    import mfh_pkg::*;
    default clocking dc @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_done_cause: assert property (micro_done_out |->
        $past(micro_timing_in && |sequence_enable_n_in)) else $error("finish without cause");
    a_done_follows: assert property (micro_timing_in && |sequence_enable_n_in
        && !clear_button_in && !power_up_clear_in |=> micro_done_out)
        else $error("finish missing");
    a_mar_step: assert property ($changed(micro_address_out) &&
        micro_address_out != 16'h0000 |->
        micro_address_out == $past(micro_address_out) + 16'h0001)
        else $error("micro address jumped");
    a_halt_pend: assert property ($rose(halt_button_in) && run_flop_out
        |-> ##[1:3] halt_pending_out) else $error("halt not pending");
    a_halt_stop: assert property ($rose(halt_button_in)
        |-> ##[1:3] !run_flop_out) else $error("halt button ignored");
    a_src_stop: assert property (halt_src_in.halt_micro ||
        halt_src_in.fetch_parity_err |-> ##[1:2] !run_flop_out)
        else $error("halt source ignored");
    a_halted_view: assert property (!run_flop_out &&
        !$past(run_flop_out) |-> halted_state_out) else $error("halt state hidden");
    a_load_halted: assert property ($rose(console_load_timing_out) |->
        $past(halted_state_out) || $past(halted_state_out, 2))
        else $error("load timing while running");
    a_load_len: assert property ($rose(console_load_timing_out) |=>
        console_load_timing_out ##1 !console_load_timing_out)
        else $error("load timing length");
    a_grant_clear: assert property ($rose(refresh_granted_flop_out) |->
        !$past(clear_button_in)) else $error("refresh during clear");
    a_gclr_src: assert property (general_clear_out |->
        $past(clear_button_in || power_up_clear_in)) else $error("stray clear");
    a_par_bad: assert property (!$past(reset_in) |->
        parity_out.force_parity_bad == $past(bounds_in.out_of_bounds))
        else $error("bad parity wrong");
    a_par_module: assert property (!$past(reset_in) |->
        parity_out.force_parity_good_module_n == ($past(bounds_in.module_oob)
        & {4{$past(bounds_in.key_in_bounds)}})) else $error("module parity");
    c_grant: cover property ($rose(refresh_granted_flop_out));
    c_halt: cover property ($fell(run_flop_out));
    c_load: cover property ($rose(console_load_timing_out));
endmodule // mfh_ctl_monitor

bind mfh_ctl mfh_ctl_monitor mfh_ctl_monitor_inst (.*);

/* File: tb/mfh_decoder_model.sv */
// Micro decoder stand-in: a timing strobe every fourth cycle while run.
// Assumes clk_in is the system clock and reset_in is synchronous.
module mfh_decoder_model (
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    input  wire logic       run_in,
    input  wire logic       go_in,
    input  wire logic [3:0] seq_mask_in,
    output logic [3:0]      seq_en_out = 4'h0,
    output logic            timing_out = 1'h0
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] phase_r = 2'h0;  // Position within a four-cycle micro.
    // Idle enables churn every cycle, so only timing may end a micro.
    always @(posedge clk_in) begin
        phase_r <= reset_in ? 2'h0 : phase_r + 2'h1;
        timing_out <= !reset_in && go_in && run_in && phase_r == 2'h3;
        seq_en_out <= (go_in && run_in) ? seq_mask_in : ~seq_en_out;
    end
endmodule // mfh_decoder_model

/* File: tb/tb.sv */
// Self-checking bench for the sequencing control.
// Assumes the package, design, decoder model and checker compile first.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import mfh_pkg::*;
    logic clk_in, reset_in = 1'h1, micro_timing_in, go = 1'h0;
    logic [3:0] sequence_enable_n_in, mask = 4'h0, reg_addr_in = 4'h0;
    logic micro_sink_in = 0, jump_pending_in = 0, tape_run_mode_in = 0;
    logic refresh_request_in = 0, reg_write_in = 0, reg_read_in = 0;
    logic [4:0] btn = '0;  // Halt, load, clear, start, power-up.
    logic [31:0] reg_wdata_in = '0, reg_rdata_out;
    mfh_halt_src_t halt_src_in = '0;
    mfh_bounds_t bounds_in = '0;
    mfh_parity_t parity_out;
    logic [15:0] micro_address_out, m0;
    logic micro_done_out, micro_done_console_out, done_advance_ok_out,
          halt_pending_out, run_flop_out, halted_state_out, irq_out,
          console_load_timing_out, refresh_granted_flop_out,
          demand_refresh_flop_out, general_clear_out;
    int failures = 0, n_checks = 0, cyc = 0;
    int n_done, n_con, n_grant, n_load, n_gclr;
    // Bounds patterns beside the forced parity that each should give.
    logic [8:0] row_b [7] = '{9'h100, 9'h180, 9'h080, 9'h0A0, 9'h0C0,
                              9'h015, 9'h01E};
    logic [7:0] row_p [7] = '{8'h80, 8'h80, 8'h10, 8'h20, 8'h40, 8'h0A,
                              8'h00};
    mfh_ctl #(.REFRESH_TIMER(20), .DEMAND_PERIOD(200)) mfh_ctl_inst (
        .clk_in, .reset_in, .sequence_enable_n_in, .micro_timing_in,
        .micro_sink_in, .jump_pending_in, .halt_src_in, .tape_run_mode_in,
        .halt_button_in(btn[0]), .load_button_in(btn[1]),
        .clear_button_in(btn[2]), .start_button_in(btn[3]),
        .power_up_clear_in(btn[4]), .refresh_request_in, .bounds_in,
        .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
        .reg_rdata_out, .micro_done_out, .micro_done_console_out,
        .done_advance_ok_out, .micro_address_out, .halt_pending_out,
        .run_flop_out, .halted_state_out, .console_load_timing_out,
        .refresh_granted_flop_out, .demand_refresh_flop_out,
        .general_clear_out, .parity_out, .irq_out);
    mfh_decoder_model mfh_decoder_model_inst (.clk_in, .reset_in,
        .run_in(run_flop_out), .go_in(go), .seq_mask_in(mask),
        .seq_en_out(sequence_enable_n_in), .timing_out(micro_timing_in));
    initial begin
        clk_in = 1'h0;
        forever #2.5 clk_in = ~clk_in;
    end
    // Event counters and the hang guard.
    always @(posedge clk_in) begin
        cyc++;
        if (micro_done_out === 1'h1) n_done++;
        if (micro_done_console_out === 1'h1) n_con++;
        if (refresh_granted_flop_out === 1'h1) n_grant++;
        if (console_load_timing_out === 1'h1) n_load++;
        if (general_clear_out === 1'h1) n_gclr++;
        if (cyc == 10000) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic press(input int k);
        @(posedge clk_in) btn[k] <= 1'h1;
        tick(3);
        btn[k] <= 1'h0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {reg_addr_in, reg_wdata_in, reg_write_in} <= {a, d, 1'h1};
        @(posedge clk_in) reg_write_in <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_in);
        {reg_addr_in, reg_read_in} <= {a, 1'h1};
        @(posedge clk_in) reg_read_in <= 1'h0;
        #1 chk(reg_rdata_out, e);
    endtask
    task automatic final_report;
        if (failures == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        int t;
        tick(2);
        reset_in <= 1'h0;
        tick(1);
        #1 chk(run_flop_out, 0);
        chk(halted_state_out, 1);
        rd(REG_STATE, 32'h0002_0000);
        rd(4'h7, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_in) bounds_in <= mfh_bounds_t'(row_b[i]);
            @(posedge clk_in) #1 chk(parity_out, row_p[i]);
        end
        // Bad parity raises an interrupt only while unmasked.
        for (int m = 1; m >= 0; m--) begin
            wr(REG_STATUS, 32'h0000_0007);
            wr(REG_MASK, m ? 32'h0000_0004 : 32'h0000_0000);
            @(posedge clk_in) bounds_in <= mfh_bounds_t'(9'h100);
            tick(4);
            #1 chk(irq_out, m);
            bounds_in <= '0;
        end
        press(3);
        tick(2);
        #1 chk(halted_state_out, 0);
        go <= 1'h1;
        for (int k = 0; k < 5; k++) begin
            mask <= (k == 0) ? 4'h0 : 4'h1 << (k - 1);
            tick(8);
            #1 {n_done, n_con, n_grant} = '0;
            m0 = micro_address_out;
            tick(40);
            #1 chk(n_done, k ? 10 : 0);
            chk(n_con, k ? 10 : 0);
            chk(micro_address_out - m0 <= n_done &&
                micro_address_out - m0 + n_grant >= n_done, 1);
        end
        wr(REG_CONTROL, 32'h0000_0001);
        tick(20);
        #1 chk(run_flop_out, 0);
        wr(REG_CONTROL, 32'h0000_0000);
        go <= 1'h0;
        tape_run_mode_in <= 1'h1;
        for (int s = 0; s < 6; s++) begin
            if (s == 5) tape_run_mode_in <= 1'h0;
            press(3);
            @(posedge clk_in)
                halt_src_in <= mfh_halt_src_t'(s < 5 ? 5'h10 >> s : 5'h02);
            @(posedge clk_in) halt_src_in <= '0;
            tick(3);
            #1 chk(run_flop_out, s == 5);
        end
        press(0);
        #1 chk(run_flop_out, 0);
        for (int r = 0; r < 2; r++) begin
            if (r) press(3);
            #1 n_load = 0;
            press(1);
            tick(4);
            #1 chk(n_load, r ? 0 : 2);
        end
        press(0);
        for (int w = 0; w < 500 && demand_refresh_flop_out !== 1'h1; w++)
            tick(1);
        tick(1);
        for (t = 1; t < 500 && demand_refresh_flop_out !== 1'h1; t++)
            tick(1);
        chk(t, 200);
        tick(10);
        for (int c = 0; c < 3; c++) begin
            btn[2] <= (c == 1);
            micro_sink_in <= (c == 2);
            #1 n_grant = 0;
            refresh_request_in <= 1'h1;
            tick(1);
            refresh_request_in <= 1'h0;
            tick(c == 2 ? 25 : 6);
            micro_sink_in <= 1'h0;
            if (c == 2) tick(6);
            #1 chk(n_grant > 0, c == 0);
            if (c == 1) chk(general_clear_out, 1);
            btn[2] <= 1'h0;
            tick(8);
        end
        #1 n_gclr = 0;
        press(4);
        tick(2);
        #1 chk(n_gclr > 0, 1);
        final_report();
    end
endmodule // tb
